// [hw/pwm_upd_pkg.sv]
// Package with register map, field layout and types of the update control.
package pwm_upd_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [5:0] OFS_CTL      = 6'h00;
    localparam logic [5:0] OFS_LOAD     = 6'h04;
    localparam logic [5:0] OFS_CMPA     = 6'h08;
    localparam logic [5:0] OFS_CMPB     = 6'h0C;
    localparam logic [5:0] OFS_GENA     = 6'h10;
    localparam logic [5:0] OFS_GENB     = 6'h14;
    localparam logic [5:0] OFS_SYNC     = 6'h18;
    localparam logic [5:0] OFS_COUNT    = 6'h1C;
    localparam logic [5:0] OFS_STATUS   = 6'h20;

    // Field positions inside generator_control.
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_MODE_BIT   = 1;
    localparam int CTL_LOAD_BIT   = 3;
    localparam int CTL_CMPA_BIT   = 4;
    localparam int CTL_CMPB_BIT   = 5;
    localparam int CTL_GENA_LO    = 6;
    localparam int CTL_GENB_LO    = 8;
    localparam int CTL_WIDTH      = 10;

    // Reset values.
    localparam logic [9:0]  CTL_RESET  = 10'h000;
    localparam logic [15:0] LOAD_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET  = 16'h0000;
    localparam logic [11:0] GEN_RESET  = 12'h000;

    // Value returned for unmapped addresses.
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Update-mode encodings of the two-bit fields.
    localparam logic [1:0] UPD_IMMEDIATE = 2'h0;
    localparam logic [1:0] UPD_LOCAL     = 2'h2;
    localparam logic [1:0] UPD_GLOBAL    = 2'h3;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avm_req_s;

    // Handshake phase of the slave.
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_e;

endpackage

// [hw/pwm_shadow_reg.sv]
// One shadowed register with immediate, local and global update.
`timescale 1ns/1ps
module pwm_shadow_reg
    import pwm_upd_pkg::*;
#(
    parameter int          WIDTH = 16,
    parameter logic [31:0] RST   = 32'h0000_0000
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Write side.
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [1:0]       upd_mode,
    // Update events.
    input  wire logic             cnt_zero,
    input  wire logic             sync_armed,
    // Results.
    output logic [WIDTH-1:0]      active,
    output logic [WIDTH-1:0]      shadow,
    output logic                  pending
);

    typedef struct packed {
        logic [WIDTH-1:0] shadow;
        logic [WIDTH-1:0] active;
        logic             pending;
    } shadow_state_s;

    shadow_state_s st_ff;
    shadow_state_s nxt_st;

    initial begin
        if (WIDTH < 1 || WIDTH > 32) begin
            $error("pwm_shadow_reg: WIDTH out of range");
        end
    end

    // Immediate writes go straight through; others wait for their zero.
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.pending && cnt_zero &&
            (upd_mode != UPD_GLOBAL || sync_armed)) begin
            nxt_st.active  = st_ff.shadow;
            nxt_st.pending = 1'b0;
        end
        if (wr_en) begin
            nxt_st.shadow = wr_data;
            if (upd_mode == UPD_IMMEDIATE) begin
                nxt_st.active  = wr_data;
                nxt_st.pending = 1'b0;
            end else begin
                nxt_st.pending = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff <= '{shadow: RST[WIDTH-1:0], active: RST[WIDTH-1:0],
                       pending: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign active  = st_ff.active;
    assign shadow  = st_ff.shadow;
    assign pending = st_ff.pending;

endmodule

// [hw/pwm_counter.sv]
// Generator counter that counts down or up/down and flags zero.
`timescale 1ns/1ps
module pwm_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Control.
    input  wire logic             enable,
    input  wire logic             up_down,
    input  wire logic [WIDTH-1:0] load,
    // Status.
    output logic [WIDTH-1:0]      count,
    output logic                  cnt_zero
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             going_up;
    } cnt_state_s;

    cnt_state_s st_ff;
    cnt_state_s nxt_st;

    initial begin
        if (WIDTH < 2 || WIDTH > 32) begin
            $error("pwm_counter: WIDTH out of range");
        end
    end

    // Down mode wraps to load; up/down mode turns round at load and zero.
    always_comb begin
        nxt_st = st_ff;
        if (enable) begin
            if (!up_down) begin
                nxt_st.going_up = 1'b0;
                nxt_st.count = (st_ff.count == '0) ? load
                             : st_ff.count - 1'b1;
            end else if (st_ff.going_up) begin
                if (st_ff.count >= load) begin
                    nxt_st.going_up = 1'b0;
                    nxt_st.count = (load == '0) ? '0 : load - 1'b1;
                end else begin
                    nxt_st.count = st_ff.count + 1'b1;
                end
            end else begin
                if (st_ff.count == '0) begin
                    nxt_st.going_up = (load != '0);
                    nxt_st.count = (load == '0) ? '0
                                 : {{(WIDTH-1){1'b0}}, 1'b1};
                end else begin
                    nxt_st.count = st_ff.count - 1'b1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign count    = st_ff.count;
    assign cnt_zero = enable && (st_ff.count == '0);

endmodule

// [hw/pwm_shadow_update_control.sv]
// Register-update control of one PWM generator behind an Avalon-MM slave.
//
// How it works
// - Bits 9:8 set action B update mode: 0 now, 2 local, 3 global.
// - Bits 7:6 set action A update mode with the same encoding.
// - Mode 0 applies an action write to the generator at once.
// - Mode 2 holds the write and applies it at the next zero.
// - Mode 3 applies the held write at first zero after global request.
// - Bit 4 clear: compare A at next zero; set: after global request.
// - Bit 5 does the same for compare B.
// - Bit 3 does the same for the load value.
// - All update-mode fields reset to zero.
// - Zero comes from a down or up/down counter chosen by the mode bit.
`timescale 1ns/1ps
module pwm_shadow_update_control
    import pwm_upd_pkg::*;
#(
    parameter int CNT_WIDTH = 16,
    parameter int ACT_WIDTH = 12
) (
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Avalon-MM slave.
    input  wire logic [5:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [3:0]           avs_byteenable,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // Values in force at the generator.
    output logic [ACT_WIDTH-1:0]      output_action_a,
    output logic [ACT_WIDTH-1:0]      output_action_b,
    output logic [CNT_WIDTH-1:0]      compare_a,
    output logic [CNT_WIDTH-1:0]      compare_b,
    output logic [CNT_WIDTH-1:0]      counter_value,
    output logic                      counter_zero
);

    initial begin
        if (CNT_WIDTH < 2 || CNT_WIDTH > 16 || ACT_WIDTH < 1 ||
            ACT_WIDTH > 12) begin
            $error("pwm_shadow_update_control: width out of range");
        end
    end

    // Whole module state.
    typedef struct packed {
        bus_state_e  bus;
        logic [31:0] rdata;
        logic [9:0]  ctl;
        logic        sync_armed;
    } top_state_s;

    top_state_s st_ff;
    top_state_s nxt_st;

    avm_req_s req;
    logic     access;
    logic     wr_hit;
    logic     wr_load;
    logic     wr_cmpa;
    logic     wr_cmpb;
    logic     wr_gena;
    logic     wr_genb;
    logic     wr_sync;
    logic     cnt_zero;
    logic     any_global_done;

    logic [1:0] mode_load;
    logic [1:0] mode_cmpa;
    logic [1:0] mode_cmpb;
    logic [1:0] mode_gena;
    logic [1:0] mode_genb;

    logic [CNT_WIDTH-1:0] load_act;
    logic [CNT_WIDTH-1:0] load_sh;
    logic [CNT_WIDTH-1:0] cmpa_sh;
    logic [CNT_WIDTH-1:0] cmpb_sh;
    logic [ACT_WIDTH-1:0] gena_sh;
    logic [ACT_WIDTH-1:0] genb_sh;
    logic [4:0]           pend;

    // Maps a single mode bit onto the two-bit encoding.
    function automatic logic [1:0] bit_mode(input logic sel);
        bit_mode = sel ? UPD_GLOBAL : UPD_LOCAL;
    endfunction

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // Request bundle and one-cycle acknowledge decode.
    always_comb begin
        req.address    = avs_address;
        req.read       = avs_read;
        req.write      = avs_write;
        req.byteenable = avs_byteenable;
        req.writedata  = avs_writedata;
    end

    assign access  = st_ff.bus == BUS_IDLE && (req.read || req.write);
    assign wr_hit  = access && req.write;
    assign wr_load = wr_hit && req.address == OFS_LOAD;
    assign wr_cmpa = wr_hit && req.address == OFS_CMPA;
    assign wr_cmpb = wr_hit && req.address == OFS_CMPB;
    assign wr_gena = wr_hit && req.address == OFS_GENA;
    assign wr_genb = wr_hit && req.address == OFS_GENB;
    assign wr_sync = wr_hit && req.address == OFS_SYNC &&
                     req.byteenable[0] && req.writedata[0];

    // Mode selection for each shadowed register.
    assign mode_gena = st_ff.ctl[CTL_GENA_LO +: 2];
    assign mode_genb = st_ff.ctl[CTL_GENB_LO +: 2];
    assign mode_cmpa = bit_mode(st_ff.ctl[CTL_CMPA_BIT]);
    assign mode_cmpb = bit_mode(st_ff.ctl[CTL_CMPB_BIT]);
    assign mode_load = bit_mode(st_ff.ctl[CTL_LOAD_BIT]);

    // Registers that waited for a global request and apply now.
    assign any_global_done = st_ff.sync_armed && cnt_zero;

    // Generator counter supplying the zero event.
    pwm_counter #(
        .WIDTH (CNT_WIDTH)
    ) u_counter (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (st_ff.ctl[CTL_ENABLE_BIT]),
        .up_down  (st_ff.ctl[CTL_MODE_BIT]),
        .load     (load_act),
        .count    (counter_value),
        .cnt_zero (cnt_zero)
    );

    // Load value shadow.
    pwm_shadow_reg #(.WIDTH(CNT_WIDTH), .RST({16'h0000, LOAD_RESET})) u_load (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .wr_en      (wr_load),
        .wr_data    (req.writedata[CNT_WIDTH-1:0]),
        .upd_mode   (mode_load),
        .cnt_zero   (cnt_zero),
        .sync_armed (st_ff.sync_armed),
        .active     (load_act),
        .shadow     (load_sh),
        .pending    (pend[0])
    );

    // Comparator A shadow.
    pwm_shadow_reg #(.WIDTH(CNT_WIDTH), .RST({16'h0000, CMP_RESET})) u_cmpa (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .wr_en      (wr_cmpa),
        .wr_data    (req.writedata[CNT_WIDTH-1:0]),
        .upd_mode   (mode_cmpa),
        .cnt_zero   (cnt_zero),
        .sync_armed (st_ff.sync_armed),
        .active     (compare_a),
        .shadow     (cmpa_sh),
        .pending    (pend[1])
    );

    // Comparator B shadow.
    pwm_shadow_reg #(.WIDTH(CNT_WIDTH), .RST({16'h0000, CMP_RESET})) u_cmpb (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .wr_en      (wr_cmpb),
        .wr_data    (req.writedata[CNT_WIDTH-1:0]),
        .upd_mode   (mode_cmpb),
        .cnt_zero   (cnt_zero),
        .sync_armed (st_ff.sync_armed),
        .active     (compare_b),
        .shadow     (cmpb_sh),
        .pending    (pend[2])
    );

    // Output action A shadow.
    pwm_shadow_reg #(.WIDTH(ACT_WIDTH), .RST({20'h0_0000, GEN_RESET})) u_gena (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .wr_en      (wr_gena),
        .wr_data    (req.writedata[ACT_WIDTH-1:0]),
        .upd_mode   (mode_gena),
        .cnt_zero   (cnt_zero),
        .sync_armed (st_ff.sync_armed),
        .active     (output_action_a),
        .shadow     (gena_sh),
        .pending    (pend[3])
    );

    // Output action B shadow.
    pwm_shadow_reg #(.WIDTH(ACT_WIDTH), .RST({20'h0_0000, GEN_RESET})) u_genb (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .wr_en      (wr_genb),
        .wr_data    (req.writedata[ACT_WIDTH-1:0]),
        .upd_mode   (mode_genb),
        .cnt_zero   (cnt_zero),
        .sync_armed (st_ff.sync_armed),
        .active     (output_action_b),
        .shadow     (genb_sh),
        .pending    (pend[4])
    );

    // Bus handshake, control register, read mux and global request flag.
    always_comb begin
        logic [31:0] ctl_word;
        ctl_word = 32'h0000_0000;
        nxt_st = st_ff;
        nxt_st.bus = access ? BUS_ACK : BUS_IDLE;
        ctl_word = merge({22'h00_0000, st_ff.ctl}, req.writedata,
                         req.byteenable);
        if (wr_hit && req.address == OFS_CTL) begin
            nxt_st.ctl = ctl_word[CTL_WIDTH-1:0];
        end
        // A request set in the same cycle as consumption stays armed.
        if (any_global_done) begin
            nxt_st.sync_armed = 1'b0;
        end
        if (wr_sync) begin
            nxt_st.sync_armed = 1'b1;
        end
        if (access && req.read) begin
            case (req.address)
                OFS_CTL:    nxt_st.rdata = {22'h00_0000, st_ff.ctl};
                OFS_LOAD:   nxt_st.rdata = 32'(load_sh);
                OFS_CMPA:   nxt_st.rdata = 32'(cmpa_sh);
                OFS_CMPB:   nxt_st.rdata = 32'(cmpb_sh);
                OFS_GENA:   nxt_st.rdata = 32'(gena_sh);
                OFS_GENB:   nxt_st.rdata = 32'(genb_sh);
                OFS_SYNC:   nxt_st.rdata = {31'h0000_0000, st_ff.sync_armed};
                OFS_COUNT:  nxt_st.rdata = 32'(counter_value);
                OFS_STATUS: nxt_st.rdata = {27'h000_0000, pend};
                default:    nxt_st.rdata = UNMAPPED_DATA;
            endcase
        end
    end

    // State register; every mode field clears on reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff.bus        <= BUS_IDLE;
            st_ff.rdata      <= 32'h0000_0000;
            st_ff.ctl        <= CTL_RESET;
            st_ff.sync_armed <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata    = st_ff.rdata;
    assign avs_waitrequest = !(st_ff.bus == BUS_ACK);
    assign counter_zero    = cnt_zero;

endmodule

// [tb/pwm_shadow_update_control_props.sv]
// Concurrent checks on the ports of the PWM register-update control.
`timescale 1ns/1ps
module pwm_shadow_update_control_props
    import pwm_upd_pkg::*;
#(
    parameter int CNT_WIDTH = 16,
    parameter int ACT_WIDTH = 12
) (
    // Clock and reset.
    input wire logic                 mclk,
    input wire logic                 rst_n,
    // Avalon-MM slave.
    input wire logic [5:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [3:0]           avs_byteenable,
    input wire logic [31:0]          avs_writedata,
    input wire logic [31:0]          avs_readdata,
    input wire logic                 avs_waitrequest,
    // Values in force at the generator.
    input wire logic [ACT_WIDTH-1:0] output_action_a,
    input wire logic [ACT_WIDTH-1:0] output_action_b,
    input wire logic [CNT_WIDTH-1:0] compare_a,
    input wire logic [CNT_WIDTH-1:0] compare_b,
    input wire logic [CNT_WIDTH-1:0] counter_value,
    input wire logic                 counter_zero
);
    typedef struct packed {
        logic [9:0] ctl;
        logic       armed;
    } chk_state_s;
    chk_state_s st_ff;
    chk_state_s nxt_st;
    logic       take;
    // A write is taken while the slave is idle, which it shows by waiting.
    assign take = avs_write && avs_waitrequest;
    // Mirror of the mode register and of the armed global request.
    always_comb begin
        nxt_st = st_ff;
        if (counter_zero) begin
            nxt_st.armed = 1'b0;
        end
        if (take && avs_address == OFS_CTL && avs_byteenable[0]) begin
            nxt_st.ctl[7:0] = avs_writedata[7:0];
        end
        if (take && avs_address == OFS_CTL && avs_byteenable[1]) begin
            nxt_st.ctl[9:8] = avs_writedata[9:8];
        end
        if (take && avs_address == OFS_SYNC && avs_byteenable[0] &&
            avs_writedata[0]) begin
            nxt_st.armed = 1'b1;
        end
    end
    // Mirror register, cleared with the design.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_take_gena;
        take && avs_address == OFS_GENA && st_ff.ctl[7:6] == UPD_IMMEDIATE;
    endsequence
    sequence s_take_genb;
        take && avs_address == OFS_GENB && st_ff.ctl[9:8] == UPD_IMMEDIATE;
    endsequence
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_wait_release;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_gena_now;
        s_take_gena |=> output_action_a == $past(avs_writedata[11:0]);
    endproperty
    property p_genb_now;
        s_take_genb |=> output_action_b == $past(avs_writedata[11:0]);
    endproperty
    property p_gena_hold;
        !$stable(output_action_a) |-> $past(counter_zero) ||
            $past(take && avs_address == OFS_GENA &&
                  st_ff.ctl[7:6] == UPD_IMMEDIATE);
    endproperty
    property p_genb_global;
        !$stable(output_action_b) && $past(st_ff.ctl[9:8]) == UPD_GLOBAL
            |-> $past(counter_zero && st_ff.armed);
    endproperty
    property p_cmpa_zero;
        !$stable(compare_a)
            |-> $past(counter_zero && (!st_ff.ctl[4] || st_ff.armed));
    endproperty
    property p_cmpb_zero;
        !$stable(compare_b)
            |-> $past(counter_zero && (!st_ff.ctl[5] || st_ff.armed));
    endproperty
    property p_zero_flag;
        counter_zero |-> counter_value == '0 && st_ff.ctl[0];
    endproperty
    property p_count_down;
        st_ff.ctl[1:0] == 2'h1 && counter_value != '0
            |=> counter_value == $past(counter_value) - 1'b1;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest did not drop after a request");
    a_wait_release: assert property (p_wait_release)
        else $error("waitrequest low for more than one cycle");
    a_gena_now: assert property (p_gena_now)
        else $error("immediate action A write not applied");
    a_genb_now: assert property (p_genb_now)
        else $error("immediate action B write not applied");
    a_gena_hold: assert property (p_gena_hold)
        else $error("action A changed away from counter zero");
    a_genb_global: assert property (p_genb_global)
        else $error("global action B applied without request");
    a_cmpa_zero: assert property (p_cmpa_zero)
        else $error("compare A changed at the wrong moment");
    a_cmpb_zero: assert property (p_cmpb_zero)
        else $error("compare B changed at the wrong moment");
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag without a zero count");
    a_count_down: assert property (p_count_down)
        else $error("down count did not step by one");
endmodule
bind pwm_shadow_update_control pwm_shadow_update_control_props #(
    .CNT_WIDTH(CNT_WIDTH),
    .ACT_WIDTH(ACT_WIDTH)
) props_i (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .output_action_a (output_action_a),
    .output_action_b (output_action_b),
    .compare_a       (compare_a),
    .compare_b       (compare_b),
    .counter_value   (counter_value),
    .counter_zero    (counter_zero)
);

// [tb/tb_pwm_shadow_update_control.sv]
// Random and corner-case bench of the PWM register-update control.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_pwm_shadow_update_control import pwm_upd_pkg::*;;
    logic        mclk;
    logic        rst_n;
    avm_req_s    req;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] output_action_a;
    logic [11:0] output_action_b;
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic [15:0] counter_value;
    logic        counter_zero;
    logic [31:0] rd;
    logic [31:0] v;
    logic [31:0] w;
    logic [15:0] ld;
    logic [15:0] m;
    int          checks;
    int          fail_count;
    int          seed;
    pwm_shadow_update_control pwm_shadow_update_control_i (
        .mclk            (mclk),
        .rst_n           (rst_n),
        .avs_address     (req.address),
        .avs_read        (req.read),
        .avs_write       (req.write),
        .avs_byteenable  (req.byteenable),
        .avs_writedata   (req.writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .output_action_a (output_action_a),
        .output_action_b (output_action_b),
        .compare_a       (compare_a),
        .compare_b       (compare_b),
        .counter_value   (counter_value),
        .counter_zero    (counter_zero)
    );
    // Clock of 10 ns period.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One Avalon-MM access held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int   n;
        logic wt;
        n = 0;
        @(posedge mclk);
        req <= '{address: a, read: !wr, write: wr, byteenable: 4'hF,
                 writedata: d};
        // Answer is sampled while it stands, ahead of the edge it meets.
        do begin
            @(negedge mclk);
            wt = avs_waitrequest;
            rd = avs_readdata;
            @(posedge mclk);
            n++;
        end while (wt && n < 50);
        req.read  <= 1'b0;
        req.write <= 1'b0;
        if (wt) begin
            fail_count++;
            test_done();
        end
    endtask
    // Waits for k counter-zero edges, then lets that edge settle.
    task automatic wait_zero(input int k);
        int n;
        n = 0;
        repeat (k) begin
            do begin
                @(negedge mclk);
                n++;
            end while (!counter_zero && n < 500);
            @(posedge mclk);
        end
        if (n >= 500) begin
            fail_count++;
        end
        #1;
    endtask
    // Highest count seen over one full period between zeros.
    task automatic period_max(output logic [15:0] mx);
        int n;
        n = 0;
        mx = '0;
        wait_zero(1);
        do begin
            @(negedge mclk);
            n++;
            if (counter_value > mx) begin
                mx = counter_value;
            end
        end while (!counter_zero && n < 500);
    endtask
    // Control word from the two action modes and the low six bits.
    function automatic logic [31:0] ctl(input logic [1:0] b,
                                        input logic [1:0] a,
                                        input logic [5:0] lo);
        return {22'h00_0000, b, a, lo};
    endfunction
    // Writes new action and compare values drawn from one word.
    task automatic put4(input logic [31:0] r);
        bus(1'b1, OFS_GENA, {20'h0_0000, r[11:0]});
        bus(1'b1, OFS_GENB, {20'h0_0000, r[23:12]});
        bus(1'b1, OFS_CMPA, {16'h0000, r[15:0]});
        bus(1'b1, OFS_CMPB, {16'h0000, r[31:16]});
    endtask
    // Compares the four values in force at the generator.
    task automatic chk4(input logic [11:0] a, input logic [11:0] b,
                        input logic [15:0] ca, input logic [15:0] cb);
        `CHK(output_action_a, a)
        `CHK(output_action_b, b)
        `CHK(compare_a, ca)
        `CHK(compare_b, cb)
    endtask
    // Watchdog against a hung handshake or counter.
    initial begin
        #400_000;
        fail_count++;
        test_done();
    end
    // Main sequence.
    initial begin
        seed = 85;
        checks = 0;
        fail_count = 0;
        rst_n = 1'b0;
        req = '0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        chk4(GEN_RESET, GEN_RESET, CMP_RESET, CMP_RESET);
        bus(1'b0, OFS_CTL, '0);
        `CHK(rd[9:0], CTL_RESET)
        bus(1'b1, 6'h3C, $random(seed));
        bus(1'b0, 6'h3C, '0);
        `CHK(rd, UNMAPPED_DATA)
        bus(1'b0, OFS_CTL, '0);
        `CHK(rd[9:0], CTL_RESET)
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            bus(1'b1, OFS_GENA, {20'h0_0000, v[11:0]});
            `CHK(output_action_a, v[11:0])
            bus(1'b1, OFS_GENB, {20'h0_0000, v[23:12]});
            `CHK(output_action_b, v[23:12])
        end
        // Local updates wait for the first zero after enabling.
        w = $random(seed);
        ld = 16'h0004 + 16'(w[2:0]);
        bus(1'b1, OFS_CTL, ctl(UPD_LOCAL, UPD_LOCAL, 6'h00));
        put4(w);
        bus(1'b1, OFS_LOAD, {16'h0000, ld});
        chk4(v[11:0], v[23:12], CMP_RESET, CMP_RESET);
        bus(1'b0, OFS_GENA, '0);
        `CHK(rd[11:0], w[11:0])
        bus(1'b1, OFS_CTL, ctl(UPD_LOCAL, UPD_LOCAL, 6'h01));
        wait_zero(1);
        chk4(w[11:0], w[23:12], w[15:0], w[31:16]);
        period_max(m);
        `CHK(m, ld)
        bus(1'b1, OFS_CTL, ctl(UPD_LOCAL, UPD_LOCAL, 6'h03));
        period_max(m);
        `CHK(m, ld)
        // Global updates wait for a request, which is then used up.
        v = $random(seed);
        bus(1'b1, OFS_CTL, ctl(UPD_GLOBAL, UPD_GLOBAL, 6'h38));
        put4(v);
        bus(1'b1, OFS_LOAD, {16'h0000, ld + 16'h0003});
        bus(1'b1, OFS_CTL, ctl(UPD_GLOBAL, UPD_GLOBAL, 6'h39));
        wait_zero(3);
        chk4(w[11:0], w[23:12], w[15:0], w[31:16]);
        period_max(m);
        `CHK(m, ld)
        bus(1'b1, OFS_SYNC, 32'h0000_0001);
        wait_zero(2);
        chk4(v[11:0], v[23:12], v[15:0], v[31:16]);
        period_max(m);
        `CHK(m, ld + 16'h0003)
        bus(1'b0, OFS_SYNC, '0);
        `CHK(rd[0], 1'b0)
        put4(w);
        wait_zero(3);
        chk4(v[11:0], v[23:12], v[15:0], v[31:16]);
        bus(1'b0, OFS_STATUS, '0);
        `CHK(rd[4:0], 5'h1E)
        // Reserved action mode 1 waits for a zero like local mode.
        bus(1'b1, OFS_CTL, ctl(2'h1, 2'h1, 6'h39));
        wait_zero(1);
        chk4(w[11:0], w[23:12], v[15:0], v[31:16]);
        test_done();
    end
endmodule
